//--- shared/ldo_regs_pkg.sv
`default_nettype none
package ldo_regs_pkg;
    // register offsets, printed offsets are not multiples of four: index, byte address is 4x
    localparam logic [7:0] CH4_CTRL_IDX = 8'h51;
    localparam logic [7:0] CH5_VOLT_IDX = 8'h54;
    localparam logic [7:0] CH5_CTRL_IDX = 8'h55;
    localparam logic [7:0] CH6_VOLT_IDX = 8'h60;
    localparam logic [7:0] CH6_CTRL_IDX = 8'h61;
    localparam logic [7:0] CH7_VOLT_IDX = 8'h64;
    localparam logic [7:0] CH7_CTRL_IDX = 8'h65;
    localparam int         ADDR_W       = 10;
    localparam int         NUM_CH       = 3;
    // control field positions
    localparam int         ENABLE_BIT    = 7;
    localparam int         DISCHARGE_BIT = 6;
    localparam int         LOW_QUIESCENT_MODE_BIT     = 5;
    localparam int         DELAY_HI      = 4;
    localparam int         DELAY_LO      = 2;
    localparam int         FAULT_BIT     = 1;
    localparam int         PGOOD_BIT     = 0;
    localparam int         VSEL_W        = 6;
    // reset values
    localparam logic [5:0] VSEL_RESET = 6'h00;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // answer to an unmapped address
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : ldo_regs_pkg
`default_nettype wire

//--- hdl/ldo_control_register_bank.sv
// Overview of operation
// - channels 5 to 7: six-bit read/write voltage select in low bits of voltage register, none for channel 4
// - control bit 7 is regulator enable, one on, zero off
// - control bit 6 enables output discharge while channel is shut down
// - control bit 5 selects low quiescent mode when one
// - control bits 4..2 hold turn-on delay code for sequencing
// - control bit 1 allows channel faults to raise the interrupt
// - control bit 0 reads power-good comparator, also for channel 4
// - voltage register bits 7..6 are reserved and read-only
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ldo_control_register_bank
    import ldo_regs_pkg::*;
(
    input  wire logic              clk_i,            // 50 MHz clock
    input  wire logic              rst_i,            // sync reset, high
    input  wire logic              cyc_i,            // wishbone cycle
    input  wire logic              stb_i,            // wishbone strobe
    input  wire logic              we_i,             // write enable
    input  wire logic [ADDR_W-1:0] adr_i,            // byte address
    input  wire logic [3:0]        sel_i,            // byte selects
    input  wire logic [31:0]       dat_i,            // write data
    output logic      [31:0]       dat_o,            // read data
    output logic                   ack_o,            // acknowledge
    input  wire logic [NUM_CH:0]   power_good_i,     // comparators, bit0 = ch4
    input  wire logic [NUM_CH-1:0] fault_i,          // fault detect ch5..7
    output logic [NUM_CH-1:0]      regulator_on_o,   // enable per channel
    output logic [NUM_CH-1:0]      discharge_o,      // discharge path on
    output logic [NUM_CH-1:0]      low_quiescent_o,  // low iq mode
    output logic [3*NUM_CH-1:0]    delay_code_o,     // turn-on delay codes
    output logic [VSEL_W*NUM_CH-1:0] voltage_select_o, // output level codes
    output logic [NUM_CH-1:0]      fault_irq_o       // per-channel fault request
);

    // bus decode
    // a request is taken while cyc and stb stand and no ack is out yet;
    // the ack follows one edge later and stands for a single cycle.
    // a write lands at the edge where the master samples that ack, so
    // address, direction and data have all stood for a full cycle by then
    // and nothing lands for a request that is dropped before its ack.
    // only the low byte lane carries register data, so sel_i[0] gates writes.
    wire logic              req_w     = cyc_i & stb_i & ~ack_o;
    wire logic              commit_w  = cyc_i & stb_i & ack_o;
    wire logic [7:0]        idx_w     = adr_i[ADDR_W-1:2];
    wire logic              wr_w      = commit_w & we_i & sel_i[0];
    wire logic              ch4_hit_w = (idx_w == CH4_CTRL_IDX);
    logic [NUM_CH-1:0]      volt_hit_w;
    logic [NUM_CH-1:0]      ctrl_hit_w;
    logic [VSEL_W-1:0]      vsel_q [NUM_CH];
    logic [6:0]             ctrl_q [NUM_CH];
    logic [NUM_CH:0]        pgood_q;
    logic [7:0]             rd_byte_w [NUM_CH];
    logic [7:0]             rd_or_w;
    logic [7:0]             ch4_byte_w;
    logic [31:0]            rd_word_w;

    // register map, one byte per word index (byte address is 4x index)
    //   ch4 control  : power-good only, everything else reads zero
    //   ch5 voltage  : six-bit level code, top two bits reserved
    //   ch5 control  : enable, discharge, low iq, delay, allow, power-good
    //   ch6 voltage  : as ch5
    //   ch6 control  : as ch5
    //   ch7 voltage  : as ch5
    //   ch7 control  : as ch5
    // any other index reads zero and ignores writes, but is still acked,
    // so a stray access never hangs the bus.

    // power-good sampled into status register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pgood_q <= '0;
        else
            pgood_q <= power_good_i;
    end

    // one slice per regulator channel: decode, storage, read byte, pins
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : gen_ch
            // word indices of this channel's two registers
            localparam logic [7:0] VIDX = (g == 0) ? CH5_VOLT_IDX : (g == 1) ? CH6_VOLT_IDX : CH7_VOLT_IDX;
            localparam logic [7:0] CIDX = (g == 0) ? CH5_CTRL_IDX : (g == 1) ? CH6_CTRL_IDX : CH7_CTRL_IDX;

            // named control fields; stored bit k sits at position k-1,
            // since the power-good bit 0 has no storage of its own
            wire logic       en_w;
            wire logic       dis_w;
            wire logic       low_quiescent_mode_w;
            wire logic [2:0] delay_w;
            wire logic       allow_w;
            wire logic       vwr_w;
            wire logic       cwr_w;

            // address match for this channel
            assign volt_hit_w[g] = (idx_w == VIDX);
            assign ctrl_hit_w[g] = (idx_w == CIDX);

            // write strobes, only at the acked edge
            assign vwr_w = wr_w & volt_hit_w[g];
            assign cwr_w = wr_w & ctrl_hit_w[g];

            // field breakout from the stored control bits
            assign en_w    = ctrl_q[g][ENABLE_BIT-1];
            assign dis_w   = ctrl_q[g][DISCHARGE_BIT-1];
            assign low_quiescent_mode_w = ctrl_q[g][LOW_QUIESCENT_MODE_BIT-1];
            assign delay_w = ctrl_q[g][DELAY_HI-1:DELAY_LO-1];
            assign allow_w = ctrl_q[g][FAULT_BIT-1];

            // voltage select storage; reserved bits 7..6 are not kept
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    vsel_q[g] <= VSEL_RESET;
                else if (vwr_w)
                    vsel_q[g] <= dat_i[VSEL_W-1:0];
            end

            // control storage; a write to bit 0 has nowhere to land
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    ctrl_q[g] <= CTRL_RESET;
                else if (cwr_w)
                    ctrl_q[g] <= dat_i[7:1];
            end

            // read data for this channel, reserved bits zero
            assign rd_byte_w[g] = volt_hit_w[g] ? {2'h0, vsel_q[g]}
                                : ctrl_hit_w[g] ? {ctrl_q[g], pgood_q[g+1]}
                                : 8'h00;

            // regulator enable pin
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    regulator_on_o[g] <= CTRL_RESET[ENABLE_BIT-1];
                else
                    regulator_on_o[g] <= en_w;
            end

            // discharge path, only while the channel is shut down
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    discharge_o[g] <= 1'b0;
                else
                    discharge_o[g] <= dis_w & ~en_w;
            end

            // low quiescent mode select
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    low_quiescent_o[g] <= CTRL_RESET[LOW_QUIESCENT_MODE_BIT-1];
                else
                    low_quiescent_o[g] <= low_quiescent_mode_w;
            end

            // turn-on delay code handed to the sequencer
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    delay_code_o[3*g+:3] <= CTRL_RESET[DELAY_HI-1:DELAY_LO-1];
                else
                    delay_code_o[3*g+:3] <= delay_w;
            end

            // output level code
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    voltage_select_o[VSEL_W*g+:VSEL_W] <= VSEL_RESET;
                else
                    voltage_select_o[VSEL_W*g+:VSEL_W] <= vsel_q[g];
            end

            // fault request, a level that follows the fault while allowed;
            // not sticky, so whoever takes it must latch it if needed
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    fault_irq_o[g] <= 1'b0;
                else
                    fault_irq_o[g] <= fault_i[g] & allow_w;
            end
        end
    endgenerate

    // channel 4 control reads power-good alone, writes to it are dropped
    assign ch4_byte_w = ch4_hit_w ? {7'h00, pgood_q[0]} : 8'h00;

    // read mux
    assign rd_or_w = rd_byte_w[0] | rd_byte_w[1] | rd_byte_w[2]
                   | (ch4_hit_w ? {7'h00, pgood_q[0]} : 8'h00);

    // full read word, upper lanes always zero
    assign rd_word_w = {24'h000000, rd_or_w};

    // ack one cycle per request; req_w drops while ack is out,
    // so a master that keeps stb up cannot stretch the pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req_w;
    end

    // read data registered with the ack, zero outside it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= UNMAPPED_DATA;
        else if (req_w)
            dat_o <= rd_word_w;
        else
            dat_o <= UNMAPPED_DATA;
    end

endmodule : ldo_control_register_bank
`default_nettype wire

//--- tb/ldo_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ldo_bank_checker
    import ldo_regs_pkg::*;
(
    input wire logic              clk_i,            // clock
    input wire logic              rst_i,            // sync reset
    input wire logic              cyc_i,            // bus cycle
    input wire logic              stb_i,            // bus strobe
    input wire logic              we_i,             // write enable
    input wire logic              ack_o,            // acknowledge
    input wire logic [ADDR_W-1:0] adr_i,            // byte address
    input wire logic [3:0]        sel_i,            // byte selects
    input wire logic [3:0]        power_good_i,     // comparators
    input wire logic [31:0]       dat_i,            // write data
    input wire logic [31:0]       dat_o,            // read data
    input wire logic [2:0]        fault_i,          // fault levels
    input wire logic [2:0]        regulator_on_o,   // enables
    input wire logic [2:0]        discharge_o,      // discharge paths
    input wire logic [2:0]        low_quiescent_o,  // low iq modes
    input wire logic [2:0]        fault_irq_o,      // fault requests
    input wire logic [8:0]        delay_code_o,     // delay codes
    input wire logic [17:0]       voltage_select_o  // level codes
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request taken; a write lands at the edge that sees the ack
    wire take = cyc_i && stb_i && !ack_o;
    wire wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> ack_o) else $error("request not acked");
    a_idle_data: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    a_vsel_write: assert property (wr && adr_i == {CH5_VOLT_IDX, 2'h0} |=> ##1
        voltage_select_o[5:0] == $past(dat_i[5:0], 2)) else $error("level code not applied");
    a_ctrl_write: assert property (wr && adr_i == {CH5_CTRL_IDX, 2'h0} |=> ##1
        {regulator_on_o[0], low_quiescent_o[0], delay_code_o[2:0]}
        == {$past(dat_i[7], 2), $past(dat_i[5:2], 2)}) else $error("control not applied");
    a_discharge_off: assert property ((discharge_o & regulator_on_o) == 3'h0)
        else $error("discharge while on");
    a_irq_cause: assert property ((fault_irq_o & ~$past(fault_i)) == 3'h0)
        else $error("request without fault");
    a_pg_read: assert property (take && !we_i && adr_i == {CH4_CTRL_IDX, 2'h0} && !$past(rst_i)
        |=> dat_o[0] == $past(power_good_i[0], 2)) else $error("power good misread");
    c_write: cover property (ack_o && we_i);
    c_read: cover property (ack_o && !we_i);
    c_irq: cover property (fault_irq_o != 3'h0);
endmodule : ldo_bank_checker
bind ldo_control_register_bank ldo_bank_checker ldo_bank_checker_i (.*);
`default_nettype wire

//--- tb/ldo_control_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ldo_control_register_bank_tb
    import ldo_regs_pkg::*;
;
    logic              clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [ADDR_W-1:0] adr_i = '0;
    logic [3:0]        sel_i = 4'hF, power_good_i = 4'h3;
    logic [31:0]       dat_i = '0, dat_o;
    logic [2:0]        fault_i = 3'h7, regulator_on_o, discharge_o, low_quiescent_o, fault_irq_o;
    logic [8:0]        delay_code_o;
    logic [17:0]       voltage_select_o;
    logic [7:0]        q;
    int                n_fail = 0, checked = 0, cycles = 0;
    // index, written byte, expected read byte
    logic [23:0] tbl [6] = '{24'h54FF3F, 24'h55FFFF, 24'h654040, 24'h51FF01, 24'h70FF00, 24'h642A2A};
    wire [38:0] outs = {regulator_on_o, discharge_o, low_quiescent_o, delay_code_o, voltage_select_o, fault_irq_o};
    ldo_control_register_bank ldo_control_register_bank_i (.*);
    always #10 clk_i = ~clk_i;
    // watchdog on the whole run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            finish_test();
        end
    end
    // one classic cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] ix, d, output logic [7:0] rd);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {ix, 2'h0}; dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        `CHK(dat_o[31:8], 24'h000000)
        cyc_i <= 0; stb_i <= 0;
    endtask : wb
    task automatic finish_test();
        if (n_fail == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // write then read back every entry, then check the pins
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        foreach (tbl[i])
        begin
            wb(1, tbl[i][23:16], tbl[i][15:8], q);
            wb(0, tbl[i][23:16], 8'h00, q);
            `CHK(q, tbl[i][7:0])
        end
        repeat (2) @(posedge clk_i);
        `CHK(outs, 39'h1840F501F9)
        fault_i <= 3'h0;
        repeat (2) @(posedge clk_i);
        `CHK(fault_irq_o, 3'h0)
        // write without the low byte lane is dropped
        sel_i <= 4'hE;
        wb(1, CH6_VOLT_IDX, 8'h15, q);
        sel_i <= 4'hF;
        wb(0, CH6_VOLT_IDX, 8'h00, q);
        `CHK(q, 8'h00)
        // reset in mid-run clears registers and pins
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        wb(0, CH5_VOLT_IDX, 8'h00, q);
        `CHK(q, 8'h00)
        `CHK(outs, 39'h0)
        finish_test();
    end
endmodule : ldo_control_register_bank_tb
`default_nettype wire
